// ===== rtl/dp_pkg.sv
// Shared constants and types for the debug link register select block
package dp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Link register addresses held by the address select register
  localparam logic [7:0] ADDR_IDENT     = 8'h00;  // Device identity, read only
  localparam logic [7:0] ADDR_REV       = 8'h01;  // Silicon revision, read only
  localparam logic [7:0] ADDR_PROG_CTL  = 8'h02;  // Programming control
  localparam logic [7:0] ADDR_PROG_DATA = 8'hAD;  // Programming data

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] ADDR_SEL_RESET = 8'h00;  // Address select after reset
  localparam logic [7:0] PROG_CTL_RESET = 8'h00;  // Programming control after reset
  localparam logic [7:0] SHIFT_RESET    = 8'h00;  // Shift register after reset
  localparam logic [7:0] READ_NONE      = 8'h00;  // Unmapped or locked read value

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock sequence written to the programming control register
  localparam logic [7:0] UNLOCK_FIRST  = 8'h02;  // First code
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;  // Second code

  ////////////////////////////////////////////////////////////////////////////////
  // Flash command codes carried by the programming data register
  localparam logic [7:0] CMD_BLOCK_READ  = 8'h06;  // Block read
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;  // Block write
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h08;  // Page erase
  localparam logic [7:0] CMD_DEV_ERASE   = 8'h03;  // Full device erase

  ////////////////////////////////////////////////////////////////////////////////
  // Frame layout counts
  localparam logic [3:0] INSTR_LAST = 4'h1;  // Index of last instruction bit
  localparam logic [3:0] DATA_LAST  = 4'h7;  // Index of last data bit
  localparam logic [3:0] CNT_RESET  = 4'h0;  // Bit counter after reset

  ////////////////////////////////////////////////////////////////////////////////
  // Link instructions, sent least significant bit first
  typedef enum logic [1:0] {
    DP_INS_DATA_RD = 2'h0,  // Read register chosen by address select
    DP_INS_DATA_WR = 2'h1,  // Write register chosen by address select
    DP_INS_ADDR_RD = 2'h2,  // Read address select itself
    DP_INS_ADDR_WR = 2'h3   // Write address select itself
  } dp_instr_type;

  // Synchronised link pins
  typedef struct packed {
    logic clk_pin;   // Link clock level
    logic data_pin;  // Link data level
  } dp_pins_type;

  // A finished write frame
  typedef struct packed {
    dp_instr_type instr;  // Instruction of the frame
    logic [7:0]   data;   // Byte written
  } dp_link_op_type;

endpackage

// ===== rtl/dp_sync.sv
// Two flip-flop synchroniser for the link pins
`timescale 1ns/1ps
module dp_sync (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire dp_pkg::dp_pins_type pins_in,
  output dp_pkg::dp_pins_type      pins_out
);

  dp_pkg::dp_pins_type stage1;  // First stage, read only by the second

  ////////////////////////////////////////////////////////////////////////////////
  // Idle link reads as clock high, data high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1   <= '1;
      pins_out <= '1;
    end else begin
      stage1   <= pins_in;
      pins_out <= stage1;
    end
  end

endmodule

// ===== rtl/dp_shift.sv
// Byte shift register, loads in parallel, shifts right with serial input
`timescale 1ns/1ps
module dp_shift (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       shift,
  input  wire logic       serial_in,
  output logic      [7:0] q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Load wins over shift; bit 0 is the next bit out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= dp_pkg::SHIFT_RESET;
    end else if (load) begin
      q <= load_value;
    end else if (shift) begin
      q <= {serial_in, q[7:1]};
    end
  end

endmodule

// ===== rtl/dp_port.sv
// Target side of the two-wire debug link with its register select set
//
// How it works
// [RULE_01] Host clock plus one shared data line
// [RULE_02] Eight-bit address select, reset zero, picks target
// [RULE_03] Address 0x00 reads the identity register
// [RULE_04] Address 0x01 reads the revision register
// [RULE_05] Address 0x02 reads and writes programming control
// [RULE_06] Address 0xAD reads and writes programming data
// [RULE_07] Identity is a fixed read-only code
// [RULE_08] Revision is a read-only revision code
// [RULE_09] Writing 0x02 then 0x01 unlocks programming
// [RULE_10] Unlock holds until system reset
// [RULE_11] These registers reachable only over the link
// [RULE_12] Data register carries commands 06 07 08 03
// [RULE_13] Host normally talks while device is halted
// [RULE_14] Writes to identity and revision are ignored
`timescale 1ns/1ps
module dp_port #(
  parameter logic [7:0] IDENT_CODE = 8'hA5,  // Arbitrary value
  parameter logic [7:0] REV_CODE   = 8'h00   // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       link_clock_pin,
  input  wire logic       link_data_pin_in,
  output logic            link_data_pin_out,
  output logic            link_data_pin_oe_n,
  input  wire logic [7:0] prog_data_rd_byte,
  output logic            prog_data_rd_strobe,
  output logic            prog_data_wr_valid,
  output logic      [7:0] prog_data_wr_byte,
  output logic            prog_data_cmd_valid,
  output logic            prog_enabled,
  output logic      [7:0] link_address_select,
  output logic      [7:0] flash_prog_control
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_WDATA, ST_RDATA, ST_RELEASE} dp_state_type;
  typedef enum logic [1:0] {UL_LOCKED, UL_FIRST, UL_OPEN} dp_unlock_type;

  dp_pkg::dp_pins_type    pins_raw;    // Raw pins
  dp_pkg::dp_pins_type    pins;        // Synchronised pins
  logic                   clk_prev;    // Last synced clock level
  logic                   link_rise;   // Link clock rising edge seen
  logic                   link_fall;   // Link clock falling edge seen
  dp_state_type           state;       // Frame state
  dp_unlock_type          unlock;      // Unlock sequence state
  logic             [3:0] bit_cnt;     // Bit index in the current field
  logic             [1:0] instr_bits;  // Instruction shift
  dp_pkg::dp_instr_type   instr;       // Instruction once complete
  logic             [7:0] shreg;       // Data shift register
  logic             [7:0] rd_value;    // Byte a read frame returns
  logic                   rd_load;     // Load read byte into shifter
  logic                   wr_fire;     // Last write bit taken
  dp_pkg::dp_link_op_type op;          // Write frame being finished
  logic                   ctl_wr;      // Write to programming control
  logic                   dat_wr;      // Write to programming data
  logic                   cmd_known;   // Written byte is a flash command

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding on the sampled link clock [RULE_01]
  assign pins_raw.clk_pin  = link_clock_pin;
  assign pins_raw.data_pin = link_data_pin_in;

  dp_sync u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // Previous clock level, reset to the idle high level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= pins.clk_pin;
    end
  end

  assign link_rise = pins.clk_pin & ~clk_prev;
  assign link_fall = ~pins.clk_pin & clk_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the finished frame
  assign instr   = dp_pkg::dp_instr_type'({pins.data_pin, instr_bits[1]});
  assign wr_fire = (state == ST_WDATA) && link_rise && (bit_cnt == dp_pkg::DATA_LAST);
  assign rd_load = (state == ST_INSTR) && link_rise && (bit_cnt == dp_pkg::INSTR_LAST)
                   && ((instr == dp_pkg::DP_INS_DATA_RD) || (instr == dp_pkg::DP_INS_ADDR_RD));
  assign op.instr = dp_pkg::dp_instr_type'(instr_bits);
  assign op.data  = {pins.data_pin, shreg[7:1]};
  // Identity and revision addresses decode to no write at all
  assign ctl_wr = wr_fire && (op.instr == dp_pkg::DP_INS_DATA_WR)
                  && (link_address_select == dp_pkg::ADDR_PROG_CTL);  // RULE_14
  assign dat_wr = wr_fire && (op.instr == dp_pkg::DP_INS_DATA_WR)
                  && (link_address_select == dp_pkg::ADDR_PROG_DATA);
  assign cmd_known = (op.data == dp_pkg::CMD_BLOCK_READ) || (op.data == dp_pkg::CMD_BLOCK_WRITE)
                  || (op.data == dp_pkg::CMD_PAGE_ERASE) || (op.data == dp_pkg::CMD_DEV_ERASE);

  ////////////////////////////////////////////////////////////////////////////////
  // Read selection; only the link reaches these registers [RULE_11]
  always_comb begin
    rd_value = dp_pkg::READ_NONE;
    if (instr == dp_pkg::DP_INS_ADDR_RD) begin
      rd_value = link_address_select;  // RULE_02
    end else begin
      unique case (link_address_select)
        dp_pkg::ADDR_IDENT:     rd_value = IDENT_CODE;          // RULE_03 RULE_07
        dp_pkg::ADDR_REV:       rd_value = REV_CODE;            // RULE_04 RULE_08
        dp_pkg::ADDR_PROG_CTL:  rd_value = flash_prog_control;  // RULE_05
        // Flash side data only shows once programming is open
        dp_pkg::ADDR_PROG_DATA: rd_value = prog_enabled ? prog_data_rd_byte
                                                        : dp_pkg::READ_NONE;  // RULE_06
        default:                rd_value = dp_pkg::READ_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared shift register: writes shift in, reads load and shift out
  dp_shift u_shift (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .load       (rd_load),
    .load_value (rd_value),
    .shift      (((state == ST_WDATA) || (state == ST_RDATA)) && link_rise),
    .serial_in  (pins.data_pin),
    .q          (shreg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame state machine; the host samples on rise, we change data on fall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      bit_cnt    <= dp_pkg::CNT_RESET;
      instr_bits <= 2'h0;
    end else begin
      unique case (state)
        // Start bit: data low at a rising edge
        ST_IDLE: begin
          if (link_rise && !pins.data_pin) begin
            state   <= ST_INSTR;
            bit_cnt <= dp_pkg::CNT_RESET;
          end
        end
        // Two instruction bits, least significant first
        ST_INSTR: begin
          if (link_rise) begin
            instr_bits <= {pins.data_pin, instr_bits[1]};
            bit_cnt    <= bit_cnt + 4'h1;
            if (bit_cnt == dp_pkg::INSTR_LAST) begin
              bit_cnt <= dp_pkg::CNT_RESET;
              state   <= rd_load ? ST_RDATA : ST_WDATA;
            end
          end
        end
        // Eight host bits, then back to idle
        ST_WDATA: begin
          if (link_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == dp_pkg::DATA_LAST) begin
              state <= ST_IDLE;
            end
          end
        end
        // Eight device bits; the last rise hands over to release
        ST_RDATA: begin
          if (link_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == dp_pkg::DATA_LAST) begin
              state <= ST_RELEASE;
            end
          end
        end
        // Hold the last bit until the next fall so the host sees it settled
        ST_RELEASE: begin
          if (link_fall) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data pin driver; driven only inside a read field [RULE_01]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_data_pin_out  <= 1'b1;
      link_data_pin_oe_n <= 1'b1;
    end else if (state == ST_RDATA && link_fall) begin
      link_data_pin_out  <= shreg[0];
      link_data_pin_oe_n <= 1'b0;
    end else if (state == ST_RELEASE && link_fall) begin
      link_data_pin_out  <= 1'b1;
      link_data_pin_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address select register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_address_select <= dp_pkg::ADDR_SEL_RESET;
    end else if (wr_fire && op.instr == dp_pkg::DP_INS_ADDR_WR) begin
      link_address_select <= op.data;  // RULE_02
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programming control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_prog_control <= dp_pkg::PROG_CTL_RESET;
    end else if (ctl_wr) begin
      flash_prog_control <= op.data;  // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock sequence; a wrong code restarts it, and open is left only by reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock       <= UL_LOCKED;
      prog_enabled <= 1'b0;
    end else begin
      unique case (unlock)
        UL_LOCKED: begin
          if (ctl_wr && op.data == dp_pkg::UNLOCK_FIRST) begin
            unlock <= UL_FIRST;  // RULE_09
          end
        end
        UL_FIRST: begin
          if (ctl_wr && op.data == dp_pkg::UNLOCK_SECOND) begin
            unlock       <= UL_OPEN;  // RULE_09
            prog_enabled <= 1'b1;
          end else if (ctl_wr && op.data != dp_pkg::UNLOCK_FIRST) begin
            unlock <= UL_LOCKED;
          end
        end
        // No exit: the host must reset the system to resume normal work
        UL_OPEN: begin
          prog_enabled <= 1'b1;  // RULE_10
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programming data traffic towards the flash engine
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_data_wr_valid  <= 1'b0;
      prog_data_wr_byte   <= dp_pkg::SHIFT_RESET;
      prog_data_cmd_valid <= 1'b0;
      prog_data_rd_strobe <= 1'b0;
    end else begin
      // Locked writes are dropped so a stray host cannot reach the flash
      prog_data_wr_valid  <= dat_wr && prog_enabled;              // RULE_06
      prog_data_cmd_valid <= dat_wr && prog_enabled && cmd_known;  // RULE_12
      prog_data_rd_strobe <= rd_load && prog_enabled
                             && instr == dp_pkg::DP_INS_DATA_RD
                             && link_address_select == dp_pkg::ADDR_PROG_DATA;
      if (dat_wr && prog_enabled) begin
        prog_data_wr_byte <= op.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  addr_write_a: assert property (wr_fire && op.instr == dp_pkg::DP_INS_ADDR_WR |=> // RULE_02
    link_address_select == $past(op.data)) else $error("address select not written");
  ident_read_a: assert property (rd_load && instr == dp_pkg::DP_INS_DATA_RD // RULE_03
    && link_address_select == dp_pkg::ADDR_IDENT |=> shreg == IDENT_CODE)
    else $error("identity read wrong");
  rev_read_a: assert property (rd_load && instr == dp_pkg::DP_INS_DATA_RD // RULE_04
    && link_address_select == dp_pkg::ADDR_REV |=> shreg == REV_CODE)
    else $error("revision read wrong");
  ctl_write_a: assert property (ctl_wr |=> flash_prog_control == $past(op.data)) // RULE_05
    else $error("control write lost");
  dat_write_a: assert property (dat_wr && prog_enabled |=> prog_data_wr_valid // RULE_06
    && prog_data_wr_byte == $past(op.data)) else $error("data write not forwarded");
  unlock_order_a: assert property ($rose(prog_enabled) |-> $past(ctl_wr) // RULE_09
    && $past(op.data) == dp_pkg::UNLOCK_SECOND && $past(unlock) == UL_FIRST)
    else $error("unlock without sequence");
  unlock_hold_a: assert property (prog_enabled |=> prog_enabled) // RULE_10
    else $error("unlock dropped before reset");
  cmd_decode_a: assert property (prog_data_cmd_valid |-> prog_data_wr_valid // RULE_12
    && (prog_data_wr_byte == dp_pkg::CMD_BLOCK_READ
    || prog_data_wr_byte == dp_pkg::CMD_BLOCK_WRITE
    || prog_data_wr_byte == dp_pkg::CMD_PAGE_ERASE
    || prog_data_wr_byte == dp_pkg::CMD_DEV_ERASE))
    else $error("bad command flag");
  ro_ignore_a: assert property (wr_fire && op.instr == dp_pkg::DP_INS_DATA_WR // RULE_14
    && link_address_select <= dp_pkg::ADDR_REV |=> !prog_data_wr_valid
    && $stable(flash_prog_control)) else $error("read-only write had effect");
  pin_idle_a: assert property (state == ST_IDLE |-> link_data_pin_oe_n) // RULE_01
    else $error("data pin driven outside read");

  unlock_c: cover property ($rose(prog_enabled));
  ident_c:  cover property (rd_load && link_address_select == dp_pkg::ADDR_IDENT);
  cmd_c:    cover property (prog_data_cmd_valid);

endmodule

// ===== sim/dp_host.sv
// Host programmer model that drives the link clock and shares the data wire
`timescale 1ns/1ps
module dp_host (
  input  wire logic clk,
  input  wire logic link_data_pin_out,
  input  wire logic link_data_pin_oe_n,
  output logic      link_clock_pin,
  output logic      link_data_pin_in
);
  logic drv_en;   // Host drives the wire
  logic drv_val;  // Level the host drives

  // Idle link: clock high, wire held high by the host
  initial begin
    link_clock_pin = 1'b1;
    drv_en = 1'b1;
    drv_val = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared wire: device first, then host, else the pull-up wins
  assign link_data_pin_in = !link_data_pin_oe_n ? link_data_pin_out :
                            (drv_en ? drv_val : 1'b1);

  // One half period, four system clocks; samples the wire before it moves
  task automatic half(input logic c, input logic en, input logic v, output logic s);
    @(posedge clk);
    s = link_data_pin_in;
    link_clock_pin <= c;
    drv_en <= en;
    drv_val <= v;
    repeat (3) @(posedge clk);
  endtask

  // Host bit: set on the fall, taken by the device on the rise
  task automatic bit_out(input logic v);
    logic s;
    half(1'b0, 1'b1, v, s);
    half(1'b1, 1'b1, v, s);
  endtask

  // Whole frame: start bit, two instruction bits, then eight data bits
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic s;
    rd = 8'h00;
    bit_out(1'b0);
    bit_out(ins[0]);
    bit_out(ins[1]);
    if (ins[0] == 1'b0) begin
      // Read: wire released, each bit sampled at the rise
      for (int i = 0; i < 8; i++) begin
        half(1'b0, 1'b0, 1'b0, s);
        half(1'b1, 1'b0, 1'b0, s);
        rd[i] = s;
      end
      half(1'b0, 1'b0, 1'b0, s);
    end else begin
      for (int i = 0; i < 8; i++) begin
        bit_out(wd[i]);
      end
      half(1'b0, 1'b1, 1'b1, s);
    end
    half(1'b1, 1'b1, 1'b1, s);
  endtask
endmodule

// ===== sim/dp_port_bench.sv
// Self-checking bench for the debug link register select block
`timescale 1ns/1ps
module dp_port_bench;
  localparam logic [7:0] IDENT_P = 8'h5C;  // Arbitrary identity value
  localparam logic [7:0] REV_P   = 8'h13;  // Arbitrary revision value
  logic       clk, sys_rst, lk_clk, lk_in, lk_out, lk_oe_n;  // Clock, reset, link
  logic [7:0] rd_src, wr_byte, addr_sel, ctl;   // Flash byte and register outputs
  logic       rd_stb, wr_vld, cmd_vld, prog_en;  // Pulses and unlock level
  int         fail_count, total_checks, rd_cnt, e_rd, m_stage;  // Counters
  logic [7:0] m_addr, m_ctl, u;  // Model registers, random byte
  logic       m_en;              // Model unlock state
  logic [8:0] got_q[$], exp_q[$];  // Seen and expected data writes
  logic [7:0] atab[6];           // Address table
  logic [7:0] seq[6];            // Bytes for a run of data writes

  dp_port #(.IDENT_CODE(IDENT_P), .REV_CODE(REV_P)) dp_port_inst (
    .clk(clk), .sys_rst(sys_rst), .link_clock_pin(lk_clk), .link_data_pin_in(lk_in),
    .link_data_pin_out(lk_out), .link_data_pin_oe_n(lk_oe_n), .prog_data_rd_byte(rd_src),
    .prog_data_rd_strobe(rd_stb), .prog_data_wr_valid(wr_vld), .prog_data_wr_byte(wr_byte),
    .prog_data_cmd_valid(cmd_vld), .prog_enabled(prog_en), .link_address_select(addr_sel),
    .flash_prog_control(ctl));
  dp_host dp_host_inst (.clk(clk), .link_data_pin_out(lk_out),
    .link_data_pin_oe_n(lk_oe_n), .link_clock_pin(lk_clk), .link_data_pin_in(lk_in));

  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pulse monitor; registers sampled here still hold the pulse cycle values
  always @(posedge clk) begin
    if (wr_vld === 1'b1) got_q.push_back({cmd_vld, wr_byte});
    if (rd_stb === 1'b1) rd_cnt++;
  end

  // Watchdog: about six times the expected run
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    final_report();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string w);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, w, got, exp);
    end
  endtask

  // Model read value for the current address select
  function automatic logic [7:0] exp_rd();
    case (m_addr)
      8'h00: return IDENT_P;
      8'h01: return REV_P;
      8'h02: return m_ctl;
      8'hAD: return m_en ? rd_src : 8'h00;
      default: return 8'h00;
    endcase
  endfunction

  // Model data write; a wrong code restarts the unlock, 02 arms it again
  task automatic model_wr(input logic [7:0] d);
    if (m_addr == 8'h02) begin
      m_ctl = d;
      if (m_stage == 1 && d == 8'h01) m_en = 1'b1;
      m_stage = (d == 8'h02) ? 1 : 0;
    end else if (m_addr == 8'hAD && m_en) begin
      exp_q.push_back({(d inside {8'h06, 8'h07, 8'h08, 8'h03}), d});
    end
  endtask

  // One frame, then every register output and pulse against the model
  task automatic op(input logic [1:0] ins, input logic [7:0] wdat);
    logic [7:0] r;
    @(posedge clk);
    rd_src <= 8'($urandom);
    @(posedge clk);
    dp_host_inst.frame(ins, wdat, r);
    if (ins == 2'h0) begin
      chk_byte(r, exp_rd(), "data read");
      if (m_addr == 8'hAD && m_en) e_rd++;
    end else if (ins == 2'h2) chk_byte(r, m_addr, "address read");
    else if (ins == 2'h3) m_addr = wdat;
    else model_wr(wdat);
    repeat (2) @(posedge clk);
    chk_byte(addr_sel, m_addr, "address select");
    chk_byte(ctl, m_ctl, "control register");
    chk_byte({7'h00, prog_en}, {7'h00, m_en}, "programming enable");
    chk_num(rd_cnt, e_rd, "read strobes");
    chk_num(got_q.size(), exp_q.size(), "write pulses");
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      chk_byte(got_q[0][7:0], exp_q[0][7:0], "written byte");
      chk_byte({7'h00, got_q[0][8]}, {7'h00, exp_q[0][8]}, "command flag");
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  endtask

  // Reset with the link idle; model returns to its reset state
  task automatic do_reset(input int n);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    m_addr = 8'h00;
    m_ctl = 8'h00;
    m_en = 1'b0;
    m_stage = 0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    rd_src = 8'h00;
    void'($urandom(32'h3E47734A));
    do_reset(10);
    op(2'h2, 8'h00);
    $display("test reset values done");
    do u = 8'($urandom); while (u inside {8'h00, 8'h01, 8'h02, 8'hAD});
    atab = '{8'h00, 8'h01, 8'h02, 8'hAD, u, 8'hFF};
    foreach (atab[i]) begin
      op(2'h3, atab[i]);
      op(2'h2, 8'h00);
      op(2'h0, 8'h00);
    end
    $display("test address table done");
    for (int a = 0; a < 2; a++) begin
      op(2'h3, 8'(a));
      op(2'h1, 8'($urandom));
      op(2'h0, 8'h00);
    end
    op(2'h3, 8'hAD);
    op(2'h1, 8'h06);
    op(2'h0, 8'h00);
    $display("test read only and locked done");
    op(2'h3, 8'h02);
    seq = '{8'h02, 8'h05, 8'h01, 8'h02, 8'h02, 8'h01};
    foreach (seq[i]) op(2'h1, seq[i]);
    op(2'h0, 8'h00);
    $display("test unlock done");
    op(2'h3, 8'hAD);
    seq = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h05, u};
    foreach (seq[i]) op(2'h1, seq[i]);
    op(2'h0, 8'h00);
    op(2'h0, 8'h00);
    $display("test commands done");
    op(2'h3, 8'h02);
    op(2'h1, 8'h00);
    op(2'h1, 8'($urandom));
    do_reset(2);
    op(2'h2, 8'h00);
    op(2'h0, 8'h00);
    $display("test reset clears unlock done");
    final_report();
  end
endmodule
